// file: include/emac_pkg.sv
// Package for the energy accumulation mode control block.
// Shared constants, register indices, field positions and carrier structs.
// Register indices are word indices; the byte address is four times each.
package emac_pkg;

  // Widths
  localparam int DW = 32;
  localparam int AW = 8;
  localparam int SW = 16;
  localparam int PW = SW + 2;
  localparam int IDX_W = AW - 2;
  localparam int INT_W = 20;
  localparam int NPH = 3;
  localparam int NACC = 9;

  // Register word indices
  localparam logic [IDX_W-1:0] IDX_ENERGY0 = 6'h01;
  localparam logic [IDX_W-1:0] IDX_LINE_RATE = 6'h10;
  localparam logic [IDX_W-1:0] IDX_COMP_MODE = 6'h16;
  localparam logic [IDX_W-1:0] IDX_LCYC_MODE = 6'h17;
  localparam logic [IDX_W-1:0] IDX_INT_MASK = 6'h18;
  localparam logic [IDX_W-1:0] IDX_INT_STATUS = 6'h19;
  localparam logic [IDX_W-1:0] IDX_LCYC_COUNT = 6'h1C;

  // Quantity order inside the accumulator array: index = quantity*3 + phase
  localparam int Q_ACT = 0;
  localparam int Q_REACT = 1;
  localparam int Q_APP = 2;

  // computation_mode fields
  localparam int CM_SEL_LO = 0;
  localparam int CM_TERM_LO = 2;
  localparam int CM_ABS = 5;
  localparam int CM_SIGN_ADJUSTED_REACTIVE_PULSE = 6;
  localparam int CM_IDLE = 7;

  // line_cycle_mode fields
  localparam int LC_ACT = 0;
  localparam int LC_REACT = 1;
  localparam int LC_APP = 2;
  localparam int LC_ZX_LO = 3;
  localparam int LC_CLR = 6;
  localparam int LC_PERIOD = 7;

  // Interrupt bit of the line-cycle-complete event
  localparam int INT_LCYC_DONE = 12;

  // accum_input_select codes
  localparam logic [1:0] SEL_OWN = 2'h0;
  localparam logic [1:0] SEL_MEAN = 2'h1;
  localparam logic [1:0] SEL_A = 2'h2;

  // Reset values
  localparam logic [7:0] COMP_MODE_RST = 8'h1C;
  localparam logic [7:0] LCYC_MODE_RST = 8'h78;
  localparam logic [15:0] LCYC_COUNT_RST = 16'h0064;

  // Pulse output scaling
  localparam int PACC_W = 24;
  localparam logic [PACC_W-1:0] PULSE_THRESH = 24'h010000;
  localparam logic [PW-1:0] IDLE_LEVEL = 18'h00010;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [AW-1:0] paddr;
    logic [DW-1:0] pwdata;
  } emac_apb_req_s;

  typedef struct packed {
    logic [DW-1:0] prdata;
    logic pready;
    logic pslverr;
  } emac_apb_rsp_s;

  // Per-sample measurements; active and reactive are two's complement
  typedef struct packed {
    logic valid;
    logic [NPH-1:0][SW-1:0] active;
    logic [NPH-1:0][SW-1:0] reactive;
    logic [NPH-1:0][SW-1:0] vrms;
    logic [NPH-1:0][SW-1:0] irms;
  } emac_meas_s;

  typedef struct packed {
    logic [7:0] comp_mode;
    logic [7:0] lcyc_mode;
    logic [15:0] lcyc_count;
    logic [15:0] zx_count;
    logic [INT_W-1:0] int_status;
    logic [INT_W-1:0] int_mask;
    logic irq;
    logic [NACC-1:0][DW-1:0] energy;
    logic [NACC-1:0][DW-1:0] work;
    emac_apb_rsp_s rsp;
  } emac_state_s;

endpackage

// file: logic/emac_pulse_gen.sv
// Pulse generator for one frequency output.
// Assumes one signed increment per valid sample from logic on the same clock.
`timescale 1ns/1ps
module emac_pulse_gen
  import emac_pkg::*;
#(
  parameter logic [PACC_W-1:0] THRESH = PULSE_THRESH,
  parameter logic [PW-1:0] IDLE = IDLE_LEVEL
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Energy increment
  input wire logic valid,
  input wire logic [PW-1:0] inc,
  input wire logic idle_en,
  // Output
  output logic pulse
);

  typedef struct packed {
    logic [PACC_W-1:0] acc;
    logic pulse;
  } emac_pg_s;

  emac_pg_s s;
  emac_pg_s next_s;
  logic [PW-1:0] mag;
  logic [PACC_W:0] sum;

  always_comb begin
    next_s = s;
    next_s.pulse = 1'b0;
    // Pulse rate follows magnitude; direction is not shown on this pin
    mag = inc[PW-1] ? PW'(-inc) : inc;
    sum = {1'b0, s.acc} + (PACC_W+1)'(mag);
    // Below the idle level nothing creeps into the pulse count
    if (valid && !(idle_en && mag < IDLE)) begin
      if (sum >= {1'b0, THRESH}) begin
        next_s.acc = PACC_W'(sum - {1'b0, THRESH});
        next_s.pulse = 1'b1;
      end else begin
        next_s.acc = sum[PACC_W-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign pulse = s.pulse;

endmodule // emac_pulse_gen

// file: logic/emac_mode_ctrl.sv
// Energy accumulation mode control: APB registers, per-phase accumulators,
// line-cycle accumulation and the two pulse-frequency outputs.
// Assumes measurements and zero-crossing pulses come from logic on pclk.
//
// Overview of operation
// R1: Phase B apparent input follows input select
// R2: Phases A and C apparent use own rms
// R3: Phase select bits 2-4 pick pulse phases
// R4: Magnitude-only sums absolute active per phase
// R5: Magnitude-only leaves active registers untouched
// R6: Sign-adjust flips reactive where active negative
// R7: Sign-adjust leaves reactive registers untouched
// R8: Bit 7 enables the idle threshold
// R9: Line bit 0 puts active in line mode
// R10: Line bit 1 puts reactive in line mode
// R11: Line bit 2 puts apparent in line mode
// R12: Bits 3-5 pick phases for crossing count
// R13: All enabled phases' crossings are counted
// R14: Clear-on-read zeroes energy register after read
// R15: Software clears clear-on-read in line mode
// R16: Bit 7 shows period instead of frequency
// R17: Input select at bits 0-1, 11 reserved
// R18: Line-cycle-complete event, mask bit 12
// R19: Empty phase select adds nothing to pulses
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
module emac_mode_ctrl
  import emac_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire emac_apb_req_s apb_req,
  output emac_apb_rsp_s apb_rsp,
  // Measurements and zero crossings
  input wire emac_meas_s meas,
  input wire logic [NPH-1:0] zero_cross,
  input wire logic [SW-1:0] line_line_rate_reading,
  input wire logic [SW-1:0] line_period,
  // Outputs
  output logic irq,
  output logic active_pulse_out,
  output logic reactive_pulse_out,
  output logic idle_threshold_enable
);

  emac_state_s s;
  emac_state_s next_s;

  // Decoded mode fields
  logic [1:0] accum_input_select;
  logic [NPH-1:0] pulse_phase_select;
  logic magnitude_only_active_pulse;
  logic sign_adjusted_reactive_pulse;
  logic [NPH-1:0] line_mode;
  logic [NPH-1:0] crossing_phase_select;
  logic clear_on_read_enable;
  logic period_display_select;

  assign accum_input_select = s.comp_mode[CM_SEL_LO +: 2];
  assign pulse_phase_select = s.comp_mode[CM_TERM_LO +: NPH];
  assign magnitude_only_active_pulse = s.comp_mode[CM_ABS];
  assign sign_adjusted_reactive_pulse = s.comp_mode[CM_SIGN_ADJUSTED_REACTIVE_PULSE];
  assign line_mode = {s.lcyc_mode[LC_APP], s.lcyc_mode[LC_REACT],
                      s.lcyc_mode[LC_ACT]};
  assign crossing_phase_select = s.lcyc_mode[LC_ZX_LO +: NPH];
  assign clear_on_read_enable = s.lcyc_mode[LC_CLR];
  assign period_display_select = s.lcyc_mode[LC_PERIOD];

  // Bus decode
  logic [IDX_W-1:0] idx;
  logic aligned;
  logic setup_done;
  logic access_done;
  logic is_energy;
  logic [3:0] energy_sel;
  logic mapped;

  assign idx = apb_req.paddr[AW-1:2];
  assign aligned = apb_req.paddr[1:0] == 2'h0;
  // First access cycle captures read data; the next one completes
  assign setup_done = apb_req.psel && apb_req.penable && !s.rsp.pready;
  assign access_done = apb_req.psel && apb_req.penable && s.rsp.pready;
  assign is_energy = idx >= IDX_ENERGY0 &&
                     idx < IDX_ENERGY0 + IDX_W'(NACC);
  assign energy_sel = 4'(idx - IDX_ENERGY0);
  assign mapped = aligned && (is_energy || idx == IDX_LINE_RATE ||
                  idx == IDX_COMP_MODE || idx == IDX_LCYC_MODE ||
                  idx == IDX_INT_MASK || idx == IDX_INT_STATUS ||
                  idx == IDX_LCYC_COUNT);

  // Per-sample increments, computed from measurements and the input select
  logic [NACC-1:0][DW-1:0] inc;
  logic [NPH-1:0][SW-1:0] app_v;
  logic [NPH-1:0][2*SW-1:0] app_prod;
  logic [SW:0] v_mean_sum;
  logic [PW-1:0] act_sum;
  logic [PW-1:0] react_sum;
  logic [PW-1:0] act_term;
  logic [PW-1:0] react_term;

  assign v_mean_sum = {1'b0, meas.vrms[0]} + {1'b0, meas.vrms[2]};

  always_comb begin
    app_v = meas.vrms;
    unique case (accum_input_select) // R17
      SEL_OWN: app_v[1] = meas.vrms[1]; // R1
      SEL_MEAN: app_v[1] = v_mean_sum[SW:1]; // R1
      SEL_A: app_v[1] = meas.vrms[0]; // R1
      default: app_v[1] = '0; // R17
    endcase
  end

  genvar gp;
  generate
    for (gp = 0; gp < NPH; gp++) begin : g_phase
      assign app_prod[gp] = app_v[gp] * meas.irms[gp]; // R2
      // Active and reactive registers get the plain signed terms whatever the pulse modes say
      assign inc[Q_ACT*NPH+gp] =
        {{(DW-SW){meas.active[gp][SW-1]}}, meas.active[gp]}; // R5
      assign inc[Q_REACT*NPH+gp] =
        {{(DW-SW){meas.reactive[gp][SW-1]}}, meas.reactive[gp]}; // R7
      assign inc[Q_APP*NPH+gp] =
        {{(DW-SW){1'b0}}, app_prod[gp][2*SW-1:SW]}; // R1 R2
    end
  endgenerate

  // Pulse sources; only phases in pulse_phase_select contribute
  always_comb begin
    act_sum = '0;
    react_sum = '0;
    act_term = '0;
    react_term = '0;
    for (int p = 0; p < NPH; p++) begin
      act_term = {{2{meas.active[p][SW-1]}}, meas.active[p]};
      if (magnitude_only_active_pulse && act_term[PW-1]) begin
        act_term = PW'(-act_term); // R4
      end
      react_term = {{2{meas.reactive[p][SW-1]}}, meas.reactive[p]};
      if (sign_adjusted_reactive_pulse && meas.active[p][SW-1]) begin
        react_term = PW'(-react_term); // R6
      end
      if (pulse_phase_select[p]) begin // R3 R19
        act_sum = PW'(act_sum + act_term);
        react_sum = PW'(react_sum + react_term);
      end
    end
  end

  // Zero crossings counted on every enabled phase
  logic [NPH-1:0] zx_hit;
  logic [1:0] zx_hits;
  logic [16:0] zx_total;
  logic line_done;

  assign zx_hit = zero_cross & crossing_phase_select; // R12
  assign zx_hits = 2'(zx_hit[0]) + 2'(zx_hit[1]) + 2'(zx_hit[2]); // R13
  assign zx_total = {1'b0, s.zx_count} + 17'(zx_hits);
  assign line_done = (|line_mode) && zx_hits != 2'h0 &&
                     zx_total >= {1'b0, s.lcyc_count};

  // Read data
  logic [DW-1:0] rdata;

  always_comb begin
    rdata = '0;
    if (aligned) begin
      if (is_energy) begin
        rdata = s.energy[energy_sel];
      end else if (idx == IDX_LINE_RATE) begin
        rdata = DW'(period_display_select ? line_period : line_line_rate_reading); // R16
      end else if (idx == IDX_COMP_MODE) begin
        rdata = DW'(s.comp_mode);
      end else if (idx == IDX_LCYC_MODE) begin
        rdata = DW'(s.lcyc_mode);
      end else if (idx == IDX_INT_MASK) begin
        rdata = DW'(s.int_mask);
      end else if (idx == IDX_INT_STATUS) begin
        rdata = DW'(s.int_status);
      end else if (idx == IDX_LCYC_COUNT) begin
        rdata = DW'(s.lcyc_count);
      end
    end
  end

  // State update
  always_comb begin
    next_s = s;
    next_s.rsp.pready = setup_done;
    if (setup_done) begin
      next_s.rsp.prdata = apb_req.pwrite ? '0 : rdata;
      next_s.rsp.pslverr = !mapped;
    end else if (access_done) begin
      next_s.rsp.prdata = '0;
      next_s.rsp.pslverr = 1'b0;
    end

    // Register writes
    if (access_done && apb_req.pwrite && aligned) begin
      if (idx == IDX_COMP_MODE) begin
        next_s.comp_mode = apb_req.pwdata[7:0];
      end else if (idx == IDX_LCYC_MODE) begin
        next_s.lcyc_mode = apb_req.pwdata[7:0];
      end else if (idx == IDX_INT_MASK) begin
        next_s.int_mask = apb_req.pwdata[INT_W-1:0];
      end else if (idx == IDX_INT_STATUS) begin
        next_s.int_status = s.int_status & ~apb_req.pwdata[INT_W-1:0];
      end else if (idx == IDX_LCYC_COUNT) begin
        next_s.lcyc_count = apb_req.pwdata[15:0];
      end
    end

    // Clear-on-read: take away exactly the value returned, so a sample
    // landing between capture and completion is kept
    if (access_done && !apb_req.pwrite && is_energy && aligned &&
        clear_on_read_enable) begin
      next_s.energy[energy_sel] =
        s.energy[energy_sel] - s.rsp.prdata; // R14
    end

    // Crossing counter runs only while some quantity is in line mode
    if (!(|line_mode)) begin
      next_s.zx_count = '0;
    end else if (line_done) begin
      next_s.zx_count = '0;
    end else begin
      next_s.zx_count = zx_total[15:0];
    end

    // Accumulators
    for (int q = 0; q < NPH; q++) begin
      for (int p = 0; p < NPH; p++) begin
        if (line_mode[q]) begin // R9 R10 R11
          if (line_done) begin
            next_s.energy[q*NPH+p] =
              s.work[q*NPH+p] + (meas.valid ? inc[q*NPH+p] : '0);
            next_s.work[q*NPH+p] = '0;
          end else if (meas.valid) begin
            next_s.work[q*NPH+p] = s.work[q*NPH+p] + inc[q*NPH+p];
          end
        end else begin
          next_s.work[q*NPH+p] = '0;
          if (meas.valid) begin
            next_s.energy[q*NPH+p] =
              next_s.energy[q*NPH+p] + inc[q*NPH+p];
          end
        end
      end
    end

    // Event set after software clear, so a same-cycle event survives
    if (line_done) begin
      next_s.int_status[INT_LCYC_DONE] = 1'b1; // R18
    end
    next_s.irq = |(next_s.int_status & next_s.int_mask); // R18
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.comp_mode <= COMP_MODE_RST;
      s.lcyc_mode <= LCYC_MODE_RST;
      s.lcyc_count <= LCYC_COUNT_RST;
    end else begin
      s <= next_s;
    end
  end

  emac_pulse_gen u_active_pulse (
    .pclk(pclk),
    .presetn(presetn),
    .valid(meas.valid),
    .inc(act_sum),
    .idle_en(s.comp_mode[CM_IDLE]), // R8
    .pulse(active_pulse_out)
  );

  emac_pulse_gen u_reactive_pulse (
    .pclk(pclk),
    .presetn(presetn),
    .valid(meas.valid),
    .inc(react_sum),
    .idle_en(s.comp_mode[CM_IDLE]), // R8
    .pulse(reactive_pulse_out)
  );

  assign apb_rsp = s.rsp;
  assign irq = s.irq;
  assign idle_threshold_enable = s.comp_mode[CM_IDLE]; // R8

endmodule // emac_mode_ctrl

// file: sim/emac_mode_ctrl_chk.sv
// Port assertions for the energy accumulation mode control block.
// Assumes the APB master holds each request until pready is seen.
`timescale 1ns/1ps
module emac_mode_ctrl_chk
  import emac_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus and measurements
  input wire emac_apb_req_s apb_req,
  input wire emac_apb_rsp_s apb_rsp,
  input wire emac_meas_s meas,
  input wire logic [NPH-1:0] zero_cross,
  input wire logic [SW-1:0] line_line_rate_reading,
  input wire logic [SW-1:0] line_period,
  // Outputs
  input wire logic irq,
  input wire logic active_pulse_out,
  input wire logic reactive_pulse_out,
  input wire logic idle_threshold_enable
);
  localparam logic [AW-1:0] A_CM = {IDX_COMP_MODE, 2'b00};
  localparam logic [AW-1:0] A_LC = {IDX_LCYC_MODE, 2'b00};
  localparam logic [AW-1:0] A_MK = {IDX_INT_MASK, 2'b00};
  localparam logic [AW-1:0] A_LR = {IDX_LINE_RATE, 2'b00};
  logic done;
  logic rd_ok;
  logic wr_ok;
  logic [7:0] cm_sh;
  logic [7:0] lc_sh;
  logic [INT_W-1:0] mk_sh;
  logic [1:0] age;
  assign done = apb_rsp.pready & ~apb_rsp.pslverr;
  assign rd_ok = done & ~apb_req.pwrite;
  assign wr_ok = done & apb_req.pwrite;
  // Shadows of what software wrote; age saturates after a comp mode write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cm_sh <= COMP_MODE_RST;
      lc_sh <= LCYC_MODE_RST;
      mk_sh <= '0;
      age <= 2'h3;
    end else begin
      if (wr_ok && apb_req.paddr == A_CM) begin
        cm_sh <= apb_req.pwdata[7:0];
      end
      if (wr_ok && apb_req.paddr == A_LC) begin
        lc_sh <= apb_req.pwdata[7:0];
      end
      if (wr_ok && apb_req.paddr == A_MK) begin
        mk_sh <= apb_req.pwdata[INT_W-1:0];
      end
      if (wr_ok && apb_req.paddr == A_CM) begin
        age <= 2'h0;
      end else if (age != 2'h3) begin
        age <= age + 2'h1;
      end
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_ready_after_access: assert property (
    $rose(apb_req.penable) |=> apb_rsp.pready) else $error("pready late");
  a_ready_one_cycle: assert property (
    apb_rsp.pready |=> !apb_rsp.pready) else $error("pready too long");
  a_misaligned_refused: assert property (
    apb_rsp.pready && apb_req.paddr[1:0] != 2'h0 |-> apb_rsp.pslverr)
    else $error("misaligned access accepted");
  a_quiet_read_data: assert property (
    apb_rsp.pready && (apb_rsp.pslverr || apb_req.pwrite)
    |-> apb_rsp.prdata == '0) else $error("stray read data");
  a_comp_readback:
    assert property (rd_ok && apb_req.paddr == A_CM
    |-> apb_rsp.prdata == {24'h0, cm_sh}) else $error("comp mode read");
  a_lcyc_readback:
    assert property (rd_ok && apb_req.paddr == A_LC
    |-> apb_rsp.prdata == {24'h0, lc_sh}) else $error("line mode read");
  a_rate_select:
    assert property (rd_ok && apb_req.paddr == A_LR |-> apb_rsp.prdata ==
    {16'h0, lc_sh[LC_PERIOD] ? line_period : line_line_rate_reading})
    else $error("line rate source");
  a_idle_follows:
    assert property (age == 2'h3 |-> idle_threshold_enable == cm_sh[CM_IDLE])
    else $error("idle enable mismatch");
  a_irq_masked:
    assert property (mk_sh == '0 && $past(mk_sh) == '0
    && $past(mk_sh, 2) == '0 |-> !irq) else $error("irq while masked");
  a_pulse_cause:
    assert property (active_pulse_out |-> $past(meas.valid)
    || $past(meas.valid, 2) || $past(meas.valid, 3)
    || $past(meas.valid, 4)) else $error("pulse without sample");
  c_comp_write: cover property (wr_ok && apb_req.paddr == A_CM);
  c_irq: cover property (irq);
  c_active_pulse: cover property (active_pulse_out);
  c_reactive_pulse: cover property (reactive_pulse_out);
endmodule // emac_mode_ctrl_chk

bind emac_mode_ctrl emac_mode_ctrl_chk chk_i (
  .pclk(pclk),
  .presetn(presetn),
  .apb_req(apb_req),
  .apb_rsp(apb_rsp),
  .meas(meas),
  .zero_cross(zero_cross),
  .line_line_rate_reading(line_line_rate_reading),
  .line_period(line_period),
  .irq(irq),
  .active_pulse_out(active_pulse_out),
  .reactive_pulse_out(reactive_pulse_out),
  .idle_threshold_enable(idle_threshold_enable)
);

// file: sim/energy_accum_mode_control_bench.sv
// Self-checking bench for the energy accumulation mode control block.
// Drives APB, samples and crossings itself; expects the bound checker.
`timescale 1ns/1ps
module energy_accum_mode_control_bench
  import emac_pkg::*;
;
  logic pclk;
  logic presetn;
  emac_apb_req_s req;
  emac_apb_rsp_s rsp;
  emac_meas_s meas;
  logic [NPH-1:0] zc;
  logic [SW-1:0] lf;
  logic [SW-1:0] lp;
  logic irq;
  logic apo;
  logic rpo;
  logic idle;
  int mismatches = 0;
  int compares = 0;
  int cyc = 0;
  int apc = 0;
  int rpc = 0;

  emac_mode_ctrl uut (.pclk(pclk), .presetn(presetn), .apb_req(req),
    .apb_rsp(rsp), .meas(meas), .zero_cross(zc), .line_line_rate_reading(lf),
    .line_period(lp), .irq(irq), .active_pulse_out(apo),
    .reactive_pulse_out(rpo), .idle_threshold_enable(idle));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic end_of_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Ceiling is far above the few hundred cycles the scenarios need
  always @(posedge pclk) begin
    cyc++;
    if (apo === 1'b1) apc++;
    if (rpo === 1'b1) rpc++;
    if (cyc == 20000) begin
      mismatches++;
      end_of_test;
    end
  end

  task automatic chk(input logic [DW-1:0] g, input logic [DW-1:0] x);
    compares++;
    if (g !== x) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, g, x);
    end
  endtask

  // One idle edge after each transfer keeps drivers to one write a step
  task automatic xfer(input logic w, input logic [AW-1:0] a,
      input logic [DW-1:0] d, input logic [DW-1:0] x, input logic xe);
    req.psel <= 1'b1;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge pclk);
    req.penable <= 1'b1;
    @(posedge pclk);
    while (rsp.pready !== 1'b1) @(posedge pclk);
    chk(rsp.prdata, x);
    chk({31'h0, rsp.pslverr}, {31'h0, xe});
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [IDX_W-1:0] i, input logic [DW-1:0] d);
    xfer(1'b1, {i, 2'b00}, d, '0, 1'b0);
  endtask

  task automatic rd(input logic [IDX_W-1:0] i, input logic [DW-1:0] x);
    xfer(1'b0, {i, 2'b00}, '0, x, 1'b0);
  endtask

  task automatic smp;
    meas.valid <= 1'b1;
    @(posedge pclk);
    meas.valid <= 1'b0;
    repeat (5) @(posedge pclk);
  endtask

  task automatic zx(input logic [NPH-1:0] v);
    zc <= v;
    @(posedge pclk);
    zc <= '0;
    repeat (5) @(posedge pclk);
  endtask

  task automatic t_regs;
    rd(IDX_COMP_MODE, 32'h1C);
    rd(IDX_LCYC_MODE, 32'h78);
    rd(IDX_INT_MASK, 32'h0);
    chk(idle, 1'b0);
    wr(IDX_COMP_MODE, 32'h9C);
    repeat (3) @(posedge pclk);
    chk(idle, 1'b1);
    wr(IDX_COMP_MODE, 32'h1C);
    wr(IDX_ENERGY0, 32'hFF);
    rd(IDX_ENERGY0, 32'h0);
    xfer(1'b0, 8'h59, '0, '0, 1'b1);
    xfer(1'b1, 8'hFC, 32'h55, '0, 1'b1);
    rd(IDX_LCYC_MODE, 32'h78);
  endtask

  task automatic t_app;
    logic [DW-1:0] xb [4];
    xb = '{32'h20, 32'h60, 32'h40, 32'h0};
    meas.vrms <= {16'h8000, 16'h2000, 16'h4000};
    meas.irms <= {3{16'h0100}};
    for (int s = 0; s < 4; s++) begin
      wr(IDX_COMP_MODE, 32'h1C | 32'(s));
      smp;
      rd(IDX_ENERGY0 + 6'h6, 32'h40);
      rd(IDX_ENERGY0 + 6'h7, xb[s]);
      rd(IDX_ENERGY0 + 6'h8, 32'h80);
      rd(IDX_ENERGY0 + 6'h7, 32'h0);
    end
    meas.irms <= '0;
  endtask

  task automatic t_active;
    int a0;
    meas.active <= {16'h0000, 16'hC000, 16'h4000};
    wr(IDX_COMP_MODE, 32'h1C);
    // Counts are taken as differences so only the monitor writes apc
    a0 = apc;
    smp;
    smp;
    chk(apc - a0, 0);
    wr(IDX_COMP_MODE, 32'h3C);
    smp;
    smp;
    chk(apc - a0, 1);
    rd(IDX_ENERGY0 + 6'h1, 32'hFFFF0000);
    rd(IDX_ENERGY0, 32'h10000);
    wr(IDX_COMP_MODE, 32'h20);
    smp;
    smp;
    chk(apc - a0, 1);
    // Fill to just below the threshold, then offer a sample under the
    // idle level: ignored with the threshold on, counted with it off
    meas.active <= {16'h7FF8, 16'h4000, 16'h4000};
    wr(IDX_COMP_MODE, 32'h9C);
    smp;
    meas.active <= {32'h0, 16'h0008};
    smp;
    chk(apc - a0, 1);
    wr(IDX_COMP_MODE, 32'h1C);
    smp;
    chk(apc - a0, 2);
  endtask

  task automatic t_react;
    int r0;
    meas.active <= {16'h0000, 16'h4000, 16'hC000};
    meas.reactive <= {16'h0000, 16'h4000, 16'h4000};
    wr(IDX_COMP_MODE, 32'h0C);
    r0 = rpc;
    smp;
    smp;
    chk(rpc - r0, 1);
    wr(IDX_COMP_MODE, 32'h4C);
    smp;
    smp;
    chk(rpc - r0, 1);
    rd(IDX_ENERGY0 + 6'h3, 32'h10000);
    wr(IDX_COMP_MODE, 32'h1C);
  endtask

  task automatic t_line;
    meas.active <= '0;
    meas.reactive <= '0;
    wr(IDX_LCYC_COUNT, 32'h2);
    wr(IDX_INT_MASK, 32'h1000);
    wr(IDX_LCYC_MODE, 32'h1F);
    zx(3'b011);
    chk(irq, 1'b1);
    rd(IDX_INT_STATUS, 32'h1000);
    wr(IDX_INT_STATUS, 32'h1000);
    rd(IDX_INT_STATUS, 32'h0);
    chk(irq, 1'b0);
    meas.active <= {32'h0, 16'h0100};
    meas.reactive <= {32'h0, 16'h0200};
    meas.vrms <= {32'h0, 16'h4000};
    meas.irms <= {32'h0, 16'h0100};
    smp;
    zx(3'b100);
    zx(3'b100);
    rd(IDX_INT_STATUS, 32'h0);
    zx(3'b001);
    zx(3'b001);
    rd(IDX_ENERGY0, 32'h100);
    rd(IDX_ENERGY0, 32'h100);
    rd(IDX_ENERGY0 + 6'h3, 32'h200);
    rd(IDX_ENERGY0 + 6'h6, 32'h40);
    wr(IDX_INT_MASK, 32'h0);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0);
    rd(IDX_INT_STATUS, 32'h1000);
    rd(IDX_LINE_RATE, 32'h0C35);
    wr(IDX_LCYC_MODE, 32'h98);
    rd(IDX_LINE_RATE, 32'h51EB);
  endtask

  initial begin
    presetn = 1'b0;
    req = '0;
    meas = '0;
    zc = '0;
    lf = 16'h0C35;
    lp = 16'h51EB;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs;
    t_app;
    t_active;
    t_react;
    t_line;
    end_of_test;
  end
endmodule // energy_accum_mode_control_bench
